// File: adc_buffer_sequence_control.sv
// Purpose: Buffer routing, sample-and-hold and sequence abort/restart control
// Assumes: Control bits come from logic on core_clk; one conversion per cycle
// Notes:
// Functional notes
// [R1] Codes 011, 101, 110 route buffer to channels 2, 1, 0.
// [R2] Software clears all slot hold selections before setting buffer enable.
// [R3] Buffer enable with no hold slots inserts buffer, no hold capture.
// [R4] Buffer-only mode serves exactly one of three inputs at once.
// [R5] Hold selected: charge hold capacitor, keep it until next sample.
// [R6] Running sequence may be stopped, reloaded and restarted immediately.
// [R7] Software clears enable, reloads slots, sets enable, toggles start bit.
// [R8] New sequence starts when start bit rises after being cleared.
// [R9] Undefined select codes buffer no channel.
`timescale 1ns/1ns
module adc_buffer_sequence_control (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic converter_enable,
	input wire logic software_conversion_start,
	input wire logic [2:0] buffer_select,
	input wire logic hold_buffer_only_enable,
	input wire logic [15:0] slot_hold_select,
	input wire logic [3:0] last_slot,
	output adc_ctrl_pkg::conv_out_t conv_out
);
	adc_ctrl_pkg::seq_state_t state_reg, state_next;
	logic [3:0] slot_reg, slot_next;
	logic start_prev_reg, start_prev_next;
	logic [2:0] route_reg, route_next;
	logic buf_reg, buf_next;
	logic hold_reg, hold_next;
	logic strobe_reg, strobe_next;
	logic busy_reg, busy_next;
	logic hold_pick;
	logic start_rise;
	logic [2:0] route_decode;
	logic hold_any;

	assign hold_any = |slot_hold_select;
	assign start_rise = software_conversion_start & ~start_prev_reg;
	assign hold_pick = slot_hold_select[slot_next];

	// [R1] Select decode
	// [R9] Other codes route nothing
	always_comb
	begin
		case (buffer_select)
			adc_ctrl_pkg::buf_code_ch2: route_decode = 3'h4;
			adc_ctrl_pkg::buf_code_ch1: route_decode = 3'h2;
			adc_ctrl_pkg::buf_code_ch0: route_decode = 3'h1;
			default: route_decode = 3'h0;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		slot_next = slot_reg;
		strobe_next = 1'b0;
		start_prev_next = software_conversion_start;
		// [R6] Enable low aborts at once
		if (!converter_enable)
		begin
			state_next = adc_ctrl_pkg::st_idle;
			slot_next = adc_ctrl_pkg::slot_reset;
		end
		else
		begin
			case (state_reg)
				adc_ctrl_pkg::st_idle:
				begin
					state_next = adc_ctrl_pkg::st_armed;
				end
				adc_ctrl_pkg::st_armed:
				begin
					// [R8] Start on rising edge
					if (start_rise)
					begin
						state_next = adc_ctrl_pkg::st_run;
						slot_next = adc_ctrl_pkg::slot_reset;
						strobe_next = 1'b1;
					end
				end
				adc_ctrl_pkg::st_run:
				begin
					// Slots read live, not latched, so a reload takes effect at the next sample
					if (slot_reg == last_slot)
					begin
						state_next = adc_ctrl_pkg::st_armed;
					end
					else
					begin
						slot_next = slot_reg + 4'h1;
						strobe_next = 1'b1;
					end
				end
				default: state_next = adc_ctrl_pkg::st_idle;
			endcase
		end
		// Busy is registered so the port leaves a flop, not a decoder
		busy_next = (state_next == adc_ctrl_pkg::st_run);
	end

	always_comb
	begin
		// [R3] Buffer only when no hold slot chosen
		// [R4] One-hot route keeps a single input
		buf_next = hold_buffer_only_enable & ~hold_any & (route_decode != 3'h0);
		route_next = buf_next ? route_decode : 3'h0;
		// [R5] Hold charges at sample, holds till next
		hold_next = hold_reg;
		if (strobe_next)
		begin
			hold_next = slot_hold_select[slot_next];
		end
		if (!converter_enable)
		begin
			hold_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= adc_ctrl_pkg::st_idle;
			slot_reg <= adc_ctrl_pkg::slot_reset;
			start_prev_reg <= 1'b0;
			route_reg <= 3'h0;
			buf_reg <= 1'b0;
			hold_reg <= 1'b0;
			strobe_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			slot_reg <= slot_next;
			start_prev_reg <= start_prev_next;
			route_reg <= route_next;
			buf_reg <= buf_next;
			hold_reg <= hold_next;
			strobe_reg <= strobe_next;
			busy_reg <= busy_next;
		end
	end

	assign conv_out.buffer_route = route_reg;
	assign conv_out.buffer_active = buf_reg;
	assign conv_out.hold_charge = hold_reg;
	assign conv_out.slot = slot_reg;
	assign conv_out.busy = busy_reg;
	assign conv_out.sample_strobe = strobe_reg;

	sequence s_rise;
		converter_enable && software_conversion_start && !start_prev_reg && state_reg == adc_ctrl_pkg::st_armed;
	endsequence

	sequence s_abort;
		!converter_enable;
	endsequence

	sequence s_go;
		converter_enable && software_conversion_start && !start_prev_reg;
	endsequence

	// [R1] Channel 2 code
	chk_route_ch2: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(buffer_select == 3'h3 && hold_buffer_only_enable && !hold_any) |=> route_reg == 3'h4)
		else $error("ch2 route wrong");
	// [R1] Channel 1 code
	chk_route_ch1: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(buffer_select == 3'h5 && hold_buffer_only_enable && !hold_any) |=> route_reg == 3'h2)
		else $error("ch1 route wrong");
	// [R1] Channel 0 code
	chk_route_ch0: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(buffer_select == 3'h6 && hold_buffer_only_enable && !hold_any) |=> route_reg == 3'h1)
		else $error("ch0 route wrong");
	// [R9] Undefined codes idle
	chk_bad_code: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		(buffer_select != 3'h3 && buffer_select != 3'h5 && buffer_select != 3'h6) |=> route_reg == 3'h0)
		else $error("undefined code routed");
	// [R9] No buffer flag
	chk_bad_code_off: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		(buffer_select != 3'h3 && buffer_select != 3'h5 && buffer_select != 3'h6) |=> !buf_reg)
		else $error("undefined code buffered");
	// [R3] Hold slots block
	chk_hold_blocks: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		hold_any |=> !buf_reg)
		else $error("buffer with hold slots");
	// [R3] Buffer inserted
	chk_buffer_on: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		(hold_buffer_only_enable && !hold_any && route_decode != 3'h0) |=> buf_reg)
		else $error("buffer not inserted");
	// [R3] Enable bit needed
	chk_buffer_needs_en: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		!hold_buffer_only_enable |=> !buf_reg && route_reg == 3'h0)
		else $error("buffer without enable");
	// [R4] Single input
	chk_one_input: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
		$onehot0(route_reg) && (buf_reg == (route_reg != 3'h0)))
		else $error("route not single");
	// [R5] Hold between samples
	chk_hold_keep: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(!strobe_next && converter_enable) |=> $stable(hold_reg))
		else $error("hold changed between samples");
	// [R5] Hold slot charges
	chk_hold_charge: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(strobe_next && hold_pick) |=> hold_reg)
		else $error("hold slot not charged");
	// [R5] Plain slot skips
	chk_hold_skip: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(strobe_next && !hold_pick) |=> !hold_reg)
		else $error("hold charged for plain slot");
	// [R6] Abort clears state
	chk_abort_idle: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		!converter_enable |=> state_reg == adc_ctrl_pkg::st_idle && slot_reg == 4'h0)
		else $error("abort failed");
	// [R6] Abort quiets busy, strobe and hold
	chk_abort_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		!converter_enable |=> !conv_out.busy && !strobe_reg && !hold_reg)
		else $error("abort left outputs active");
	// [R6] Immediate restart
	chk_restart: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		s_abort ##1 converter_enable ##1 s_go |=> conv_out.busy && strobe_reg && slot_reg == 4'h0)
		else $error("restart after abort not taken");
	// [R8] Start edge taken
	chk_start_rise: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		s_rise |=> conv_out.busy && strobe_reg && slot_reg == 4'h0)
		else $error("start not taken");
	// [R8] Held start ignored
	chk_no_level_start: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		(state_reg == adc_ctrl_pkg::st_armed && start_prev_reg) |=> state_reg != adc_ctrl_pkg::st_run)
		else $error("start without edge");
	// [R8] Armed waits quietly
	chk_armed_wait: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		(state_reg == adc_ctrl_pkg::st_armed && !software_conversion_start) |=> !strobe_reg)
		else $error("sample without start");
	// [R8] Strobe inside run
	chk_strobe_busy: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		strobe_reg |-> conv_out.busy)
		else $error("strobe outside run");
endmodule : adc_buffer_sequence_control

// File: adc_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 16 sequence slots, 3 buffered channels
// Notes: Codes are active-low one-hot channel picks
package adc_ctrl_pkg;
	localparam int slot_count = 16;
	localparam int chan_count = 3;
	localparam logic [2:0] buf_code_ch2 = 3'h3;
	localparam logic [2:0] buf_code_ch1 = 3'h5;
	localparam logic [2:0] buf_code_ch0 = 3'h6;
	localparam logic [3:0] slot_reset = 4'h0;
	localparam logic [15:0] hold_reset = 16'h0000;

	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_armed = 3'h2,
		st_run = 3'h4
	} seq_state_t;

	typedef struct packed {
		logic [2:0] buffer_route;
		logic buffer_active;
		logic hold_charge;
		logic [3:0] slot;
		logic busy;
		logic sample_strobe;
	} conv_out_t;
endpackage : adc_ctrl_pkg

// File: tb_top.sv
// Purpose: Random self-check of buffer routing and sequence control
// Assumes: Outputs are registered one edge after the inputs
// Notes: Slot, hold and route are compared every cycle, idle included
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic en = 1'b0;
	logic start = 1'b0;
	logic [2:0] code = 3'h0;
	logic hbo = 1'b0;
	logic [15:0] sel = 16'h0000;
	logic [3:0] last = 4'h0;
	logic [31:0] x = 32'hE5A0;
	adc_ctrl_pkg::conv_out_t q;
	int fails = 0;
	int checks_done = 0;
	int st = 0;
	int slot = 0;
	int ps = 0;
	int busy = 0;
	int stb = 0;
	int hold = 0;
	int act = 0;
	int rt = 0;
	adc_buffer_sequence_control dut (.core_clk(core_clk), .rst_b(rst_b), .converter_enable(en),
		.software_conversion_start(start), .buffer_select(code), .hold_buffer_only_enable(hbo),
		.slot_hold_select(sel), .last_slot(last), .conv_out(q));
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic check(input string n, input logic [3:0] e, input logic [3:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, g);
		end
	endtask : check
	task automatic results();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// Integer model, updated on the same edge the design registers on
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st = 0; slot = 0; ps = 0; busy = 0; stb = 0; hold = 0; act = 0; rt = 0;
		end
		else
		begin
			rt = code == 3'h3 ? 4 : code == 3'h5 ? 2 : code == 3'h6 ? 1 : 0;
			act = hbo && sel == 16'h0000 && rt != 0;
			stb = 0;
			if (!en)
			begin
				st = 0; busy = 0; slot = 0; hold = 0;
			end
			else if (st == 0)
				st = 1;
			else if (st == 1 && start && !ps)
			begin
				st = 2; busy = 1; stb = 1; slot = 0; hold = sel[0];
			end
			else if (st == 2 && slot == last)
			begin
				st = 1; busy = 0;
			end
			else if (st == 2)
			begin
				slot = (slot + 1) % 16; stb = 1; hold = sel[slot];
			end
			ps = start;
		end
	end
	initial
	begin
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge core_clk);
		repeat (3000)
		begin
			@(negedge core_clk);
			check("busy", busy, q.busy);
			check("strobe", stb, q.sample_strobe);
			check("slot", slot, q.slot);
			check("hold", hold, q.hold_charge);
			check("active", act, q.buffer_active);
			check("route", act ? rt : 0, q.buffer_route);
			x = xs(x);
			if (!en) sel = x[9] ? 16'h0000 : x[31:16];
			// buffer enable only with no hold slots
			hbo = x[8] && sel == 16'h0000;
			en = x[3:0] != 4'h0;
			start = x[4];
			code = x[7:5];
			last = x[13:10];
		end
		results();
	end
endmodule : tb_top
